// ### pdrm_pkg.sv
// constants, types and contract of the power domain reset manager
// Contract
// R1 - timekeeping domain always powered; core, processor, graphics domains switchable
// R2 - each domain holds separately switchable islands, powered only when needed
// R3 - stop clocks of a powered but idle island
// R4 - clock gating for gated islands and for the ungated_island alike
// R5 - processor domain: four core islands, shared cache island, top island
// R6 - ungated_island stays powered whenever the core domain is on
// R7 - power_mgmt_ctrl and real-time clock live in the always-on domain
// R8 - power_mgmt_ctrl sequences supply changes into and out of low power
// R9 - power and clock request lines from other blocks steer the islands
// R10 - spi, two-wire, rtc and usb wake events leave deep sleep
// R11 - during sleep hold defined states and keep domain control
// R12 - idle islands are powered off
// R13 - primary pin reset makes separate resets for controller, rtc, clock_reset_ctrl
// R14 - clock_reset_ctrl derives block resets from the supplied reset
// R15 - thermal, watchdog, software and wake events each give a reset variant
// R16 - rtc wakes on programmed timer or external key trigger
// R17 - rtc keeps contents on backup cell and may charge it
// R18 - module drives reset pin low until its power sequence completes
// R19 - each processor core island gated independently
// R20 - island resets held until supply restored and clock enabled
// R21 - every generated reset released synchronously to the clock
package pdrm_pkg;

  // -------------------------------
  // timing
  // -------------------------------
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned RAMP_NS     = 10000;
  localparam int unsigned RAMP_CYC    = (RAMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_NS      = 2000;
  localparam int unsigned RST_CYC     = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RTC_TICK_NS = 1000000000;
  localparam int unsigned RTC_TICK_CYC = RTC_TICK_NS / CLK_NS;

  // -------------------------------
  // islands
  // -------------------------------
  localparam int unsigned NI       = 10;
  localparam logic [9:0] CPU_MASK  = 10'h03f;
  localparam logic [9:0] GPU_MASK  = 10'h040;
  localparam logic [9:0] CORE_MASK = 10'h380;

  // -------------------------------
  // reset causes
  // -------------------------------
  localparam logic [2:0] CAUSE_NONE  = 3'h0;
  localparam logic [2:0] CAUSE_PIN   = 3'h1;
  localparam logic [2:0] CAUSE_THERM = 3'h2;
  localparam logic [2:0] CAUSE_WDOG  = 3'h3;
  localparam logic [2:0] CAUSE_SW    = 3'h4;
  localparam logic [2:0] CAUSE_WAKE  = 3'h5;

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_RUN, ST_SLP_IN, ST_SLEEP, ST_WAKE, ST_SYSRST
  } pdrm_state_t;

endpackage : pdrm_pkg

// ### pdrm_top.sv
// power domain reset manager: domains, islands, clock gates and resets
`timescale 1ns/1ps
module pdrm_top #(
  parameter int unsigned RTC_TICK_CYC = pdrm_pkg::RTC_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        module_reset_pin_n_in,
  output logic             module_reset_pin_n_out,
  output logic             module_reset_pin_n_oe,
  input  wire logic        power_en,
  input  wire logic        backup_cell_input,
  input  wire logic        backup_charge_cfg,
  input  wire logic        cpu_dom_req,
  input  wire logic        gpu_dom_req,
  input  wire logic [9:0]  isl_pwr_req,
  input  wire logic [9:0]  isl_clk_req,
  input  wire logic        ungated_clk_req,
  input  wire logic        sleep_req,
  input  wire logic        wake_spi,
  input  wire logic        wake_i2c,
  input  wire logic        wake_usb,
  input  wire logic        rtc_key_n,
  input  wire logic        rtc_alarm_en,
  input  wire logic [31:0] rtc_alarm,
  input  wire logic        thermal_evt,
  input  wire logic        watchdog_expiry,
  input  wire logic        sw_reset_req,
  output logic             timekeep_dom_on,
  output logic             core_dom_on,
  output logic             cpu_dom_on,
  output logic             graphics_rail_on,
  output logic             rail_low,
  output logic [9:0]       isl_pwr_en,
  output logic [9:0]       isl_clk_en,
  output logic [9:0]       isl_rst_n,
  output logic             ungated_clk_en,
  output logic             power_mgmt_ctrl_rst_n,
  output logic             rtc_rst_n,
  output logic             clock_reset_ctrl_rst_n,
  output logic             blk_rst_n,
  output logic [2:0]       rst_cause,
  output logic             asleep,
  output logic [31:0]      rtc_seconds,
  output logic             backup_charge_en
);

  // -------------------------------
  // state and shared terms
  // -------------------------------
  pdrm_pkg::pdrm_state_t st;
  logic [7:0]  cnt;
  logic        ext_rst;
  logic        ramp_done;
  logic        rst_done;
  logic        sys_evt;
  logic        wake_any;
  logic        rtc_hit;
  logic        key_q;
  logic        power_mgmt_ctrl_q1;
  logic        rtc_q1;
  logic [23:0] pre;
  logic [9:0]  dom_vec;
  logic [9:0]  req_vec;
  logic [9:0]  want;

  // carrier pull only counts while we are not driving the pin ourselves
  assign ext_rst   = !module_reset_pin_n_in && !module_reset_pin_n_oe;
  assign ramp_done = cnt == 8'(pdrm_pkg::RAMP_CYC - 1);
  assign rst_done  = cnt == 8'(pdrm_pkg::RST_CYC - 1);
  assign sys_evt   = thermal_evt || watchdog_expiry || sw_reset_req;

  // wake sources, key is active low
  assign wake_any = wake_spi || wake_i2c || wake_usb || rtc_hit || key_q; // R10

  // domain of each island, and whether that domain is wanted
  assign dom_vec = ({10{cpu_dom_on}} & pdrm_pkg::CPU_MASK)
                 | ({10{graphics_rail_on}} & pdrm_pkg::GPU_MASK)
                 | ({10{core_dom_on}} & pdrm_pkg::CORE_MASK);
  assign req_vec = ({10{cpu_dom_req}} & pdrm_pkg::CPU_MASK)
                 | ({10{gpu_dom_req}} & pdrm_pkg::GPU_MASK)
                 | pdrm_pkg::CORE_MASK;

  // island power only while running and asked for
  assign want = {10{st == pdrm_pkg::ST_RUN}} & isl_pwr_req & dom_vec & req_vec; // R9 R12

  // -------------------------------
  // sequencer
  // -------------------------------

  // power loss wins over every state; pin reset only once we stop driving the pin, so not in ST_RAMP
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st  <= pdrm_pkg::ST_OFF;
      cnt <= 8'h00;
    end else if (ext_rst || !power_en) begin
      st  <= pdrm_pkg::ST_OFF;
      cnt <= 8'h00;
    end else begin
      unique case (st)
        pdrm_pkg::ST_OFF: begin
          st  <= pdrm_pkg::ST_RAMP;
          cnt <= 8'h00;
        end
        pdrm_pkg::ST_RAMP: begin
          cnt <= ramp_done ? 8'h00 : cnt + 8'h01;
          if (ramp_done) st <= pdrm_pkg::ST_SYSRST;
        end
        pdrm_pkg::ST_RUN: begin
          cnt <= 8'h00;
          if (sys_evt) st <= pdrm_pkg::ST_SYSRST; // R15
          else if (sleep_req) st <= pdrm_pkg::ST_SLP_IN;
        end
        pdrm_pkg::ST_SLP_IN: begin
          // long enough for every island to drop clock, reset and power
          cnt <= rst_done ? 8'h00 : cnt + 8'h01;
          if (rst_done) st <= pdrm_pkg::ST_SLEEP; // R8
        end
        pdrm_pkg::ST_SLEEP: begin
          cnt <= 8'h00;
          if (wake_any || thermal_evt) st <= pdrm_pkg::ST_WAKE; // R10
        end
        pdrm_pkg::ST_WAKE: begin
          cnt <= ramp_done ? 8'h00 : cnt + 8'h01;
          if (ramp_done) st <= pdrm_pkg::ST_SYSRST; // R15
        end
        pdrm_pkg::ST_SYSRST: begin
          cnt <= rst_done ? 8'h00 : cnt + 8'h01;
          if (rst_done) st <= pdrm_pkg::ST_RUN;
        end
      endcase
    end
  end

  // reset cause, thermal first since it is the unsafe one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cause <= pdrm_pkg::CAUSE_NONE;
    end else if (st == pdrm_pkg::ST_OFF) begin
      rst_cause <= pdrm_pkg::CAUSE_PIN;
    end else if (st == pdrm_pkg::ST_RUN && sys_evt && power_en && !ext_rst) begin
      if (thermal_evt) rst_cause <= pdrm_pkg::CAUSE_THERM; // R15
      else if (watchdog_expiry) rst_cause <= pdrm_pkg::CAUSE_WDOG; // R15
      else rst_cause <= pdrm_pkg::CAUSE_SW; // R15
    end else if (st == pdrm_pkg::ST_SLEEP && (wake_any || thermal_evt)) begin
      rst_cause <= thermal_evt ? pdrm_pkg::CAUSE_THERM : pdrm_pkg::CAUSE_WAKE; // R15
    end
  end

  // -------------------------------
  // domains and rail
  // -------------------------------

  // a domain only drops once all its islands are down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timekeep_dom_on  <= 1'b1;
      core_dom_on      <= 1'b0;
      cpu_dom_on       <= 1'b0;
      graphics_rail_on <= 1'b0;
    end else begin
      timekeep_dom_on  <= 1'b1; // R1 R7
      core_dom_on      <= st != pdrm_pkg::ST_OFF
                          || (isl_pwr_en & pdrm_pkg::CORE_MASK) != 10'h000; // R1 R11
      cpu_dom_on       <= (cpu_dom_req && (st == pdrm_pkg::ST_RUN
                          || st == pdrm_pkg::ST_SYSRST || st == pdrm_pkg::ST_WAKE))
                          || (isl_pwr_en & pdrm_pkg::CPU_MASK) != 10'h000; // R1
      graphics_rail_on <= (gpu_dom_req && st == pdrm_pkg::ST_RUN)
                          || (isl_pwr_en & pdrm_pkg::GPU_MASK) != 10'h000; // R1
    end
  end

  // rail lowers after islands are off and is raised first on wake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_low <= 1'b0;
    end else if (st == pdrm_pkg::ST_SLP_IN && rst_done) begin
      rail_low <= 1'b1; // R8
    end else if (st != pdrm_pkg::ST_SLEEP) begin
      rail_low <= 1'b0; // R8
    end
  end

  // status of sleep, frozen state is held by every register above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) asleep <= 1'b0;
    else asleep <= st == pdrm_pkg::ST_SLEEP; // R11
  end

  // -------------------------------
  // islands
  // -------------------------------

  // power, then clock, then reset release; down with clock and reset together, then power
  for (genvar i = 0; i < pdrm_pkg::NI; i++) begin : g_isl
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        isl_pwr_en[i] <= 1'b0;
        isl_clk_en[i] <= 1'b0;
        isl_rst_n[i]  <= 1'b0;
      end else if (want[i]) begin
        isl_pwr_en[i] <= 1'b1; // R2 R5 R19
        isl_clk_en[i] <= isl_pwr_en[i] && isl_clk_req[i]; // R3 R4
        isl_rst_n[i]  <= isl_pwr_en[i] && (isl_clk_en[i] || isl_rst_n[i]); // R20 R21
      end else begin
        isl_clk_en[i] <= 1'b0;
        isl_rst_n[i]  <= 1'b0; // R20
        isl_pwr_en[i] <= isl_pwr_en[i] && (isl_clk_en[i] || isl_rst_n[i]); // R12
      end
    end
  end

  // ungated island is powered with the core domain, only its clock gates
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ungated_clk_en <= 1'b0;
    else ungated_clk_en <= core_dom_on && ungated_clk_req
                           && st != pdrm_pkg::ST_SLEEP; // R4 R6
  end

  // -------------------------------
  // generated resets
  // -------------------------------

  // two flops so release lands on a clean edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mgmt_ctrl_q1    <= 1'b0;
      power_mgmt_ctrl_rst_n <= 1'b0;
      rtc_q1                <= 1'b0;
      rtc_rst_n             <= 1'b0;
    end else begin
      power_mgmt_ctrl_q1    <= !ext_rst; // R13
      power_mgmt_ctrl_rst_n <= power_mgmt_ctrl_q1; // R21
      // a backed-up clock keeps its contents across the pin reset
      rtc_q1                <= !ext_rst || (backup_cell_input && rtc_q1); // R13 R17
      rtc_rst_n             <= rtc_q1; // R21
    end
  end

  // clock_reset_ctrl reset, then block resets derived from it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_reset_ctrl_rst_n <= 1'b0;
      blk_rst_n              <= 1'b0;
    end else begin
      clock_reset_ctrl_rst_n <= power_mgmt_ctrl_rst_n && st != pdrm_pkg::ST_OFF
                   && st != pdrm_pkg::ST_RAMP; // R13 R21
      blk_rst_n              <= clock_reset_ctrl_rst_n && (st == pdrm_pkg::ST_RUN
                   || st == pdrm_pkg::ST_SLP_IN || st == pdrm_pkg::ST_SLEEP); // R14 R15
    end
  end

  // pin held low until our power sequence is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      module_reset_pin_n_out <= 1'b0;
      module_reset_pin_n_oe  <= 1'b1;
    end else begin
      module_reset_pin_n_out <= 1'b0;
      module_reset_pin_n_oe  <= st == pdrm_pkg::ST_OFF
                                || st == pdrm_pkg::ST_RAMP; // R18
    end
  end

  // -------------------------------
  // real-time clock
  // -------------------------------

  // one second tick from the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre         <= 24'h000000;
      rtc_seconds <= 32'h00000000;
    end else if (!rtc_rst_n) begin
      pre         <= 24'h000000;
      rtc_seconds <= 32'h00000000;
    end else if (pre == 24'(RTC_TICK_CYC - 1)) begin
      pre         <= 24'h000000;
      rtc_seconds <= rtc_seconds + 32'h00000001; // R7 R17
    end else begin
      pre <= pre + 24'h000001;
    end
  end

  // timer match or key press; key level is taken as synchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_hit <= 1'b0;
      key_q   <= 1'b0;
    end else begin
      rtc_hit <= rtc_alarm_en && rtc_seconds == rtc_alarm; // R16
      key_q   <= !rtc_key_n; // R16
    end
  end

  // charging needs the main supply, not the cell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) backup_charge_en <= 1'b0;
    else backup_charge_en <= backup_charge_cfg && backup_cell_input
                             && core_dom_on; // R17
  end

  // -------------------------------
  // checks
  // -------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tk_always_on: assert property (timekeep_dom_on) // R1
    else $error("timekeeping domain dropped");

  chk_isl_in_domain: assert property ((isl_pwr_en & ~dom_vec) == 10'h000) // R2
    else $error("island powered in a dead domain");

  chk_clk_needs_pwr: assert property ((isl_clk_en & ~isl_pwr_en) == 10'h000) // R3
    else $error("island clock without power");

  chk_ungated_gate: assert property (!core_dom_on |=> !ungated_clk_en) // R4
    else $error("ungated clock runs with core off");

  chk_rst_held_off: assert property ((isl_rst_n & ~isl_pwr_en) == 10'h000) // R20
    else $error("island reset released while unpowered");

  chk_rst_after_clk: assert property (
    $rose(isl_rst_n[0]) |-> $past(isl_clk_en[0])) // R20
    else $error("reset released before clock");

  chk_pin_primary: assert property (ext_rst |=> ##1 !power_mgmt_ctrl_rst_n) // R13
    else $error("pin reset did not reach controller reset");

  chk_rtc_keep: assert property (
    ext_rst && backup_cell_input && rtc_q1 |=> rtc_q1) // R17
    else $error("backed-up clock was reset");

  chk_pin_drive: assert property (st == pdrm_pkg::ST_OFF |=> module_reset_pin_n_oe) // R18
    else $error("pin not driven during power-up");

  chk_wdog_cause: assert property (
    st == pdrm_pkg::ST_RUN && watchdog_expiry && !thermal_evt && power_en && !ext_rst
    |=> rst_cause == pdrm_pkg::CAUSE_WDOG ##[1:2] !blk_rst_n) // R15
    else $error("watchdog reset variant wrong");

  chk_rail_order: assert property (
    $rose(rail_low) |-> isl_pwr_en == 10'h000 && !graphics_rail_on) // R8
    else $error("rail lowered with islands on");

  chk_wake_exit: assert property (
    st == pdrm_pkg::ST_SLEEP && wake_usb && power_en && !ext_rst
    |=> st == pdrm_pkg::ST_WAKE ##1 !rail_low) // R10
    else $error("wake event ignored");

  chk_blk_from_ctrl: assert property (!clock_reset_ctrl_rst_n |=> !blk_rst_n) // R14
    else $error("block reset ahead of clock_reset_ctrl reset");

  cov_sleep_wake: cover property (
    st == pdrm_pkg::ST_SLEEP ##1 st == pdrm_pkg::ST_WAKE);
  cov_therm_rst: cover property (rst_cause == pdrm_pkg::CAUSE_THERM && !blk_rst_n);
  cov_core_split: cover property (isl_pwr_en[0] && !isl_pwr_en[1]);
  cov_rtc_wake: cover property (rtc_hit && st == pdrm_pkg::ST_SLEEP);

endmodule : pdrm_top

// ### pdrm_board_model.sv
// board side model of the open-drain module reset pin
`timescale 1ns/1ps
module pdrm_board_model (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic carrier_pull,
  output logic      pin_level
);
  // ------------------------------
  // reset pin wire
  // ------------------------------
  // wired-and: the module or the carrier may pull low, the pull-up wins otherwise
  always_comb begin
    pin_level = !(pin_oe && !pin_out) && !carrier_pull;
  end
endmodule : pdrm_board_model

// ### tb_pdrm_top.sv
// self-checking bench for the power domain reset manager
`timescale 1ns/1ps
module tb_pdrm_top;
  typedef struct packed {
    logic [9:0] pwr;
    logic [9:0] ck;
    logic       cpu;
    logic       gpu;
    logic       ung;
    logic [9:0] e_pwr;
    logic [9:0] e_ck;
    logic [9:0] e_rst;
  } pdrm_row_t;

  logic        clk, rst_n, carrier_pull, module_reset_pin_n_in, module_reset_pin_n_out;
  logic        module_reset_pin_n_oe, power_en, backup_cell_input, backup_charge_cfg;
  logic        cpu_dom_req, gpu_dom_req, ungated_clk_req, sleep_req, wake_spi, wake_i2c;
  logic        wake_usb, rtc_key_n, rtc_alarm_en, thermal_evt, watchdog_expiry, sw_reset_req;
  logic        timekeep_dom_on, core_dom_on, cpu_dom_on, graphics_rail_on, rail_low;
  logic        ungated_clk_en, power_mgmt_ctrl_rst_n, rtc_rst_n, clock_reset_ctrl_rst_n;
  logic        blk_rst_n, asleep;
  logic        backup_charge_en;
  logic [9:0]  isl_pwr_req, isl_clk_req, isl_pwr_en, isl_clk_en, isl_rst_n;
  logic [31:0] rtc_alarm, rtc_seconds, s0;
  logic [2:0]  rst_cause;
  int          fails, n_compared;

  // ordinary island cases: requests beside expected enables and resets
  pdrm_row_t rows [6] = '{
    '{10'h03f, 10'h03f, 1'b1, 1'b0, 1'b1, 10'h03f, 10'h03f, 10'h03f},
    '{10'h03f, 10'h03a, 1'b1, 1'b0, 1'b0, 10'h03f, 10'h03a, 10'h03f},
    '{10'h03d, 10'h03d, 1'b1, 1'b0, 1'b1, 10'h03d, 10'h03d, 10'h03d},
    '{10'h3ff, 10'h3ff, 1'b0, 1'b1, 1'b1, 10'h3c0, 10'h3c0, 10'h3c0},
    '{10'h3ff, 10'h3ff, 1'b0, 1'b0, 1'b0, 10'h380, 10'h380, 10'h380},
    '{10'h000, 10'h000, 1'b0, 1'b0, 1'b0, 10'h000, 10'h000, 10'h000}};
  logic [2:0] evts [4] = '{3'h4, 3'h2, 3'h1, 3'h6};
  logic [2:0] causes [4] = '{pdrm_pkg::CAUSE_THERM, pdrm_pkg::CAUSE_WDOG,
                             pdrm_pkg::CAUSE_SW, pdrm_pkg::CAUSE_THERM};
  logic [3:0] wakes [5] = '{4'h9, 4'h5, 4'h3, 4'h0, 4'h1};

  // short tick so the seconds counter moves within the run
  pdrm_top #(.RTC_TICK_CYC(50)) dut (
    .clk, .rst_n, .module_reset_pin_n_in, .module_reset_pin_n_out, .module_reset_pin_n_oe,
    .power_en, .backup_cell_input, .backup_charge_cfg, .cpu_dom_req, .gpu_dom_req,
    .isl_pwr_req, .isl_clk_req, .ungated_clk_req, .sleep_req, .wake_spi, .wake_i2c,
    .wake_usb, .rtc_key_n, .rtc_alarm_en, .rtc_alarm, .thermal_evt, .watchdog_expiry,
    .sw_reset_req, .timekeep_dom_on, .core_dom_on, .cpu_dom_on, .graphics_rail_on,
    .rail_low, .isl_pwr_en, .isl_clk_en, .isl_rst_n, .ungated_clk_en, .power_mgmt_ctrl_rst_n,
    .rtc_rst_n, .clock_reset_ctrl_rst_n, .blk_rst_n, .rst_cause, .asleep, .rtc_seconds,
    .backup_charge_en
  );

  pdrm_board_model board (
    .pin_out(module_reset_pin_n_out), .pin_oe(module_reset_pin_n_oe),
    .carrier_pull(carrier_pull), .pin_level(module_reset_pin_n_in)
  );

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // bounded wait: a hang shows up as a mismatch, not a stall
  task automatic wait_for(ref logic sig, input logic val, input int lim, input string what);
    int n;
    n = 0;
    while (sig !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(what, val, sig);
  endtask : wait_for

  task automatic boot;
    wait_for(module_reset_pin_n_oe, 1'b0, 200, "pin_oe");
    wait_for(blk_rst_n, 1'b1, 40, "blk_rst_n");
    check("power_mgmt_ctrl_rst_n", 1, power_mgmt_ctrl_rst_n);
    check("clock_reset_ctrl_rst_n", 1, clock_reset_ctrl_rst_n);
  endtask : boot

  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // clock: 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog: about ten times the expected run length
  initial begin
    #2000000;
    fails++;
    report_and_stop();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {power_en, backup_cell_input, backup_charge_cfg, rtc_key_n} = 4'hf;
    {carrier_pull, cpu_dom_req, gpu_dom_req, ungated_clk_req, sleep_req, wake_spi, wake_i2c,
     wake_usb, rtc_alarm_en, thermal_evt, watchdog_expiry, sw_reset_req} = '0;
    {isl_pwr_req, isl_clk_req, rtc_alarm} = '0;
    cyc(10);
    check("timekeep_dom_on", 1, timekeep_dom_on);
    check("pin_oe", 1, module_reset_pin_n_oe);
    check("pin_out", 0, module_reset_pin_n_out);
    rst_n = 1'b1;
    boot();
    check("core_dom_on", 1, core_dom_on);
    check("backup_charge_en", 1, backup_charge_en);
    // island table: requesters drive their lines, islands follow
    foreach (rows[i]) begin
      {isl_pwr_req, isl_clk_req, cpu_dom_req, gpu_dom_req, ungated_clk_req} =
        {rows[i].pwr, rows[i].ck, rows[i].cpu, rows[i].gpu, rows[i].ung};
      cyc(8);
      check("isl_pwr_en", rows[i].e_pwr, isl_pwr_en);
      check("isl_clk_en", rows[i].e_ck, isl_clk_en);
      check("isl_rst_n", rows[i].e_rst, isl_rst_n);
      check("cpu_dom_on", rows[i].cpu, cpu_dom_on);
      check("graphics_rail_on", rows[i].gpu, graphics_rail_on);
      check("ungated_clk_en", rows[i].ung, ungated_clk_en);
    end
    // one-cycle system events, thermal winning over the watchdog
    foreach (evts[i]) begin
      {thermal_evt, watchdog_expiry, sw_reset_req} = evts[i];
      cyc(1);
      {thermal_evt, watchdog_expiry, sw_reset_req} = 3'h0;
      cyc(1);
      check("rst_cause", causes[i], rst_cause);
      check("blk_rst_n", 0, blk_rst_n);
      check("power_mgmt_ctrl_rst_n", 1, power_mgmt_ctrl_rst_n);
      wait_for(blk_rst_n, 1'b1, 40, "blk_rst_n");
    end
    // seconds advance by exactly two over two tick periods
    s0 = rtc_seconds;
    cyc(100);
    check("rtc_seconds", s0 + 32'h2, rtc_seconds);
    // sleep and wake by each source, the last by the timer alarm
    foreach (wakes[i]) begin
      rtc_alarm_en = (i == 4);
      rtc_alarm = rtc_seconds + 32'h2;
      sleep_req = 1'b1;
      wait_for(asleep, 1'b1, 40, "asleep");
      sleep_req = 1'b0;
      check("rail_low", 1, rail_low);
      check("timekeep_dom_on", 1, timekeep_dom_on);
      {wake_spi, wake_i2c, wake_usb, rtc_key_n} = wakes[i];
      wait_for(asleep, 1'b0, 300, "asleep");
      {wake_spi, wake_i2c, wake_usb, rtc_key_n} = 4'h1;
      rtc_alarm_en = 1'b0;
      wait_for(blk_rst_n, 1'b0, 200, "blk_rst_n");
      check("rst_cause", pdrm_pkg::CAUSE_WAKE, rst_cause);
      check("rail_low", 0, rail_low);
      // wake ramp plus reset pulse is well over a hundred cycles
      wait_for(blk_rst_n, 1'b1, 200, "blk_rst_n");
    end
    // thermal while asleep forces a wake with the thermal variant
    sleep_req = 1'b1;
    wait_for(asleep, 1'b1, 40, "asleep");
    sleep_req = 1'b0;
    thermal_evt = 1'b1;
    cyc(2);
    thermal_evt = 1'b0;
    check("rst_cause", pdrm_pkg::CAUSE_THERM, rst_cause);
    wait_for(blk_rst_n, 1'b1, 200, "blk_rst_n");
    // carrier pulls the reset pin; the rtc keeps running on the backup cell
    carrier_pull = 1'b1;
    cyc(3);
    check("power_mgmt_ctrl_rst_n", 0, power_mgmt_ctrl_rst_n);
    check("clock_reset_ctrl_rst_n", 0, clock_reset_ctrl_rst_n);
    check("pin_oe", 1, module_reset_pin_n_oe);
    check("rtc_rst_n", 1, rtc_rst_n);
    carrier_pull = 1'b0;
    boot();
    // power off: only the timekeeping domain stays on
    power_en = 1'b0;
    cyc(3);
    check("core_dom_on", 0, core_dom_on);
    check("timekeep_dom_on", 1, timekeep_dom_on);
    check("backup_charge_en", 0, backup_charge_en);
    power_en = 1'b1;
    boot();
    // islands up, then a second reset in mid-run must drop them
    {isl_pwr_req, isl_clk_req, cpu_dom_req} = {10'h3ff, 10'h3ff, 1'b1};
    cyc(8);
    check("isl_pwr_en", 10'h3bf, isl_pwr_en);
    rst_n = 1'b0;
    cyc(2);
    check("isl_pwr_en", 0, isl_pwr_en);
    check("isl_rst_n", 0, isl_rst_n);
    rst_n = 1'b1;
    boot();
    report_and_stop();
  end
endmodule : tb_pdrm_top
